//--- rs232_pkg.sv
// Shared constants, field layouts and carrier types of the serial port.
// Assumes a single 50 MHz clock; all offsets are APB byte addresses.
package rs232_pkg;
  localparam int CLK_HZ     = 50_000_000;
  localparam int OVERSAMPLE = 16;
  // Clock cycles per 16x tick for each baud rate
  localparam logic [15:0] DIV_1200   = 16'(CLK_HZ / (OVERSAMPLE * 1200));
  localparam logic [15:0] DIV_2400   = 16'(CLK_HZ / (OVERSAMPLE * 2400));
  localparam logic [15:0] DIV_4800   = 16'(CLK_HZ / (OVERSAMPLE * 4800));
  localparam logic [15:0] DIV_9600   = 16'(CLK_HZ / (OVERSAMPLE * 9600));
  localparam logic [15:0] DIV_19200  = 16'(CLK_HZ / (OVERSAMPLE * 19200));
  localparam logic [15:0] DIV_38400  = 16'(CLK_HZ / (OVERSAMPLE * 38400));
  localparam logic [15:0] DIV_57600  = 16'(CLK_HZ / (OVERSAMPLE * 57600));
  localparam logic [15:0] DIV_115200 = 16'(CLK_HZ / (OVERSAMPLE * 115200));
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_TXDATA = 12'h004;
  localparam logic [11:0] ADDR_RXDATA = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  // Control field positions and reset values
  localparam int CTRL_BAUD_LSB  = 0;
  localparam int CTRL_FMT_LSB   = 3;
  localparam int CTRL_FLOW_LSB  = 5;
  localparam int CTRL_SERIAL    = 8;
  localparam int CTRL_PANEL_LSB = 9;
  localparam logic [2:0] BAUD_RST   = 3'h6;
  localparam logic [1:0] FMT_RST    = 2'h0;
  localparam logic [2:0] FLOW_RST   = 3'h1;
  localparam logic       SERIAL_RST = 1'b0;
  localparam logic [1:0] PANEL_RST  = 2'h0;
  // Status and receive-data field positions
  localparam int ST_TXRDY   = 0;
  localparam int ST_TXBUSY  = 1;
  localparam int ST_XOFF    = 2;
  localparam int ST_ABORT   = 3;
  localparam int ST_OVR     = 4;
  localparam int ST_CNT_LSB = 8;
  localparam int RX_PERR    = 9;
  localparam int RX_VALID   = 8;
  // Encodings
  localparam logic [1:0] FMT_NONE8   = 2'h0;
  localparam logic [1:0] FMT_ODD7    = 2'h2;
  localparam logic [2:0] FLOW_NONE   = 3'h0;
  localparam logic [2:0] FLOW_XON    = 3'h1;
  localparam logic [2:0] FLOW_DTR    = 3'h2;
  localparam logic [2:0] FLOW_RTS    = 3'h3;
  localparam logic [2:0] FLOW_MODEM  = 3'h4;
  localparam logic [1:0] PANEL_LOCAL = 2'h0;
  localparam logic [1:0] PANEL_RWL   = 2'h2;
  localparam logic [7:0] CHAR_XON    = 8'h11;
  localparam logic [7:0] CHAR_XOFF   = 8'h13;
  localparam logic [7:0] CHAR_ABORT  = 8'h03;
  localparam int         RXQ_DEPTH   = 128;
  localparam logic [7:0] RXQ_HIGH    = 8'h64;
  localparam logic [7:0] RXQ_FULL    = 8'h80;

  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} bit_state_t;
  typedef struct packed {
    logic       valid;
    logic       perr;
    logic [7:0] data;
  } rx_char_t;

  // Divider for a baud selection
  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    case (sel)
      3'h0:    return DIV_1200;
      3'h1:    return DIV_2400;
      3'h2:    return DIV_4800;
      3'h3:    return DIV_9600;
      3'h4:    return DIV_19200;
      3'h5:    return DIV_38400;
      3'h6:    return DIV_57600;
      default: return DIV_115200;
    endcase
  endfunction : baud_div
endpackage : rs232_pkg

//--- tx_buf2.sv
// Two-entry transmit buffer with valid/ready on both sides and a flush.
// Assumes the writer holds its data until ready; flush beats a push.
`timescale 1ns/1ps
module tx_buf2 (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  output logic            in_ready,
  output logic            out_valid,
  output logic [7:0]      out_data,
  input  wire logic       out_ready,
  input  wire logic       flush
);
  import rs232_pkg::*;
  typedef struct packed {
    logic [7:0] d0;
    logic [7:0] d1;
    logic [1:0] cnt;
  } buf_t;
  buf_t st_reg, st_next;

  assign in_ready  = (st_reg.cnt != 2'h2);
  assign out_valid = (st_reg.cnt != 2'h0);
  assign out_data  = st_reg.d0;

  // Head is always d0; a pop shifts d1 forward
  always_comb begin
    logic push;
    logic pop;
    push = in_valid & in_ready;
    pop  = out_valid & out_ready;
    st_next = st_reg;
    if (pop) begin
      st_next.d0 = st_reg.d1;
    end
    if (push) begin
      if (st_reg.cnt == 2'h0 || (st_reg.cnt == 2'h1 && pop)) begin
        st_next.d0 = in_data;
      end else begin
        st_next.d1 = in_data;
      end
    end
    st_next.cnt = st_reg.cnt + 2'(push) - 2'(pop);
    if (flush) begin
      st_next.cnt = 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : tx_buf2

//--- rx_core.sv
// Receive deserialiser on a 16x oversampling tick.
// Assumes rxd is synchronous to pclk; a bad stop bit drops the character.
`timescale 1ns/1ps
module rx_core (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick,
  input  wire logic       rxd,
  input  wire logic [1:0] fmt,
  output rs232_pkg::rx_char_t rx_out
);
  import rs232_pkg::*;
  typedef struct packed {
    bit_state_t st;
    logic [3:0] sub;
    logic [2:0] bitn;
    logic [7:0] shift;
    logic       par;
    rx_char_t   out;
  } rxs_t;
  rxs_t st_reg, st_next;

  assign rx_out = st_reg.out;

  always_comb begin
    logic [7:0] d;
    d = (fmt == FMT_NONE8) ? st_reg.shift : {1'b0, st_reg.shift[7:1]};
    st_next = st_reg;
    st_next.out.valid = 1'b0;
    if (tick) begin
      st_next.sub = st_reg.sub + 4'h1;
      case (st_reg.st)
        S_IDLE: begin
          st_next.sub = 4'h0;
          if (!rxd) st_next.st = S_START;
        end
        // A start bit must still be low at mid-bit
        S_START: if (st_reg.sub == 4'h7) begin
          st_next.sub  = 4'h0;
          st_next.bitn = 3'h0;
          st_next.st   = rxd ? S_IDLE : S_DATA;
        end
        S_DATA: if (st_reg.sub == 4'hF) begin
          st_next.shift = {rxd, st_reg.shift[7:1]};
          st_next.bitn  = st_reg.bitn + 3'h1;
          if (st_reg.bitn == ((fmt == FMT_NONE8) ? 3'h7 : 3'h6)) begin
            st_next.st = (fmt == FMT_NONE8) ? S_STOP : S_PAR;
          end
        end
        S_PAR: if (st_reg.sub == 4'hF) begin
          st_next.par = rxd;
          st_next.st  = S_STOP;
        end
        S_STOP: if (st_reg.sub == 4'hF) begin
          st_next.st = S_IDLE;
          if (rxd) begin
            st_next.out.valid = 1'b1;
            st_next.out.data  = d;
            st_next.out.perr  = (fmt != FMT_NONE8) &
                                (st_reg.par ^ (^d) ^ (fmt == FMT_ODD7));
          end
        end
        default: st_next.st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{st: S_IDLE, shift: 8'h00, sub: 4'h0, bitn: 3'h0,
                  par: 1'b0, out: '0};
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : rx_core

//--- rs232_port.sv
// Serial remote port: APB registers, transmitter, receive queue and
// handshake lines. Assumes one 50 MHz clock and synchronous line inputs.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module rs232_port (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        cts,
  input  wire logic        dsr,
  output logic             rts,
  output logic             dtr,
  output logic             serial_active,
  output logic             keys_locked,
  output logic             local_key_locked,
  output logic             abort_pulse
);
  import rs232_pkg::*;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [2:0]  baud_sel;
    logic [1:0]  fmt;
    logic [2:0]  flow;
    logic        serial;
    logic [1:0]  panel;
    logic [15:0] div_cnt;
    logic        tick;
    bit_state_t  tx_st;
    logic [3:0]  tx_sub;
    logic [2:0]  tx_bitn;
    logic [7:0]  tx_shift;
    logic        tx_par;
    logic        txd;
    logic        xoff;
    logic        abort_flag;
    logic        ovr_flag;
    logic        abort_pulse;
    logic        rts;
    logic        dtr;
    logic        keys_locked;
    logic        local_locked;
    logic [6:0]  rd_ptr;
    logic [6:0]  wr_ptr;
    logic [7:0]  count;
  } port_t;

  port_t      st_reg, st_next;
  logic [8:0] rxq_mem [RXQ_DEPTH];
  rx_char_t   rx_char;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic [7:0] buf_out_data;
  logic       buf_pop;
  logic       buf_flush;
  logic       buf_push;
  logic       rxq_push;
  logic       rxq_pop;
  logic       done;
  logic       tx_gate;
  logic       stall;

  // Address decode used by the error answer only
  function automatic logic addr_ok(input logic [11:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_TXDATA) ||
           (a == ADDR_RXDATA) || (a == ADDR_STATUS);
  endfunction : addr_ok

  // Outputs come straight from the state flops
  assign prdata           = st_reg.prdata;
  assign pready           = st_reg.pready;
  assign pslverr          = st_reg.pslverr;
  assign txd              = st_reg.txd;
  assign rts              = st_reg.rts;
  assign dtr              = st_reg.dtr;
  assign serial_active    = st_reg.serial;
  assign keys_locked      = st_reg.keys_locked;
  assign local_key_locked = st_reg.local_locked;
  assign abort_pulse      = st_reg.abort_pulse;

  // Transfer completes on the edge where the master sees pready
  assign done = psel & penable & st_reg.pready;
  // A full transmit buffer holds the access phase instead of losing data
  assign stall = pwrite & (paddr == ADDR_TXDATA) & ~buf_in_ready;
  assign buf_push = done & pwrite & (paddr == ADDR_TXDATA);
  assign rxq_pop  = done & ~pwrite & (paddr == ADDR_RXDATA) &
                    (st_reg.count != 8'h00);

  // Transmit permission per flow mode, checked only between characters
  always_comb begin
    tx_gate = st_reg.serial;
    case (st_reg.flow)
      FLOW_XON:   tx_gate = st_reg.serial & ~st_reg.xoff;
      FLOW_DTR:   tx_gate = st_reg.serial & dsr;
      FLOW_RTS:   tx_gate = st_reg.serial & cts;
      FLOW_MODEM: tx_gate = st_reg.serial & cts & dsr;
      default:    tx_gate = st_reg.serial;
    endcase
  end

  // A new character starts only on a tick so bit timing is clean
  assign buf_pop = (st_reg.tx_st == S_IDLE) & tx_gate & st_reg.tick &
                   buf_out_valid;

  // Received abort characters, and XON/XOFF in the XON flow mode, never enter the queue
  always_comb begin
    buf_flush = 1'b0;
    rxq_push  = 1'b0;
    if (rx_char.valid && st_reg.serial) begin
      if (rx_char.data == CHAR_ABORT) begin
        buf_flush = 1'b1;
      end else if (st_reg.flow == FLOW_XON &&
                   (rx_char.data == CHAR_XON ||
                    rx_char.data == CHAR_XOFF)) begin
        rxq_push = 1'b0;
      end else begin
        rxq_push = (st_reg.count != RXQ_FULL);
      end
    end
  end

  always_comb begin
    logic       rx_high;
    logic [7:0] ld;
    rx_high = (st_reg.count >= RXQ_HIGH);
    ld = (st_reg.fmt == FMT_NONE8) ? buf_out_data
                                   : {1'b0, buf_out_data[6:0]};
    st_next = st_reg;
    st_next.abort_pulse = 1'b0;

    // APB answer is prepared in the setup cycle, no wait state unless a TXDATA write stalls
    st_next.pready = psel & ~st_reg.pready & ~stall;
    if (psel && !st_reg.pready) begin
      st_next.pslverr = ~addr_ok(paddr);
      st_next.prdata  = 32'h0000_0000;
      case (paddr)
        ADDR_CTRL: begin
          st_next.prdata[CTRL_BAUD_LSB+:3]  = st_reg.baud_sel;
          st_next.prdata[CTRL_FMT_LSB+:2]   = st_reg.fmt;
          st_next.prdata[CTRL_FLOW_LSB+:3]  = st_reg.flow;
          st_next.prdata[CTRL_SERIAL]       = st_reg.serial;
          st_next.prdata[CTRL_PANEL_LSB+:2] = st_reg.panel;
        end
        ADDR_RXDATA: begin
          st_next.prdata[RX_VALID] = (st_reg.count != 8'h00);
          if (st_reg.count != 8'h00) begin
            st_next.prdata[RX_PERR:0] = {rxq_mem[st_reg.rd_ptr][8], 1'b1,
                                         rxq_mem[st_reg.rd_ptr][7:0]};
          end
        end
        ADDR_STATUS: begin
          st_next.prdata[ST_TXRDY]  = buf_in_ready;
          st_next.prdata[ST_TXBUSY] = (st_reg.tx_st != S_IDLE) |
                                      buf_out_valid;
          st_next.prdata[ST_XOFF]   = st_reg.xoff;
          st_next.prdata[ST_ABORT]  = st_reg.abort_flag;
          st_next.prdata[ST_OVR]    = st_reg.ovr_flag;
          st_next.prdata[ST_CNT_LSB+:8] = st_reg.count;
        end
        default: st_next.prdata = 32'h0000_0000;
      endcase
    end

    // Register writes take effect on the completing edge only
    if (done && pwrite && paddr == ADDR_CTRL) begin
      st_next.baud_sel = pwdata[CTRL_BAUD_LSB+:3];
      st_next.fmt      = pwdata[CTRL_FMT_LSB+:2];
      st_next.flow     = pwdata[CTRL_FLOW_LSB+:3];
      st_next.serial   = pwdata[CTRL_SERIAL];
      st_next.panel    = pwdata[CTRL_PANEL_LSB+:2];
    end
    if (done && pwrite && paddr == ADDR_STATUS) begin
      st_next.abort_flag = st_reg.abort_flag & ~pwdata[ST_ABORT];
      st_next.ovr_flag   = st_reg.ovr_flag & ~pwdata[ST_OVR];
    end

    // Panel key lockout follows the current panel mode
    st_next.keys_locked  = (st_next.panel != PANEL_LOCAL);
    st_next.local_locked = (st_next.panel == PANEL_RWL);

    // 16x tick from the selected divider
    st_next.tick = 1'b0;
    if (st_reg.div_cnt >= baud_div(st_reg.baud_sel) - 16'h0001) begin
      st_next.div_cnt = 16'h0000;
      st_next.tick    = 1'b1;
    end else begin
      st_next.div_cnt = st_reg.div_cnt + 16'h0001;
    end

    // Receive side: flags set after clears so a set is never lost
    if (rx_char.valid && st_reg.serial) begin
      if (rx_char.data == CHAR_ABORT) begin
        st_next.abort_flag  = 1'b1;
        st_next.abort_pulse = 1'b1;
      end else if (st_reg.flow == FLOW_XON &&
                   rx_char.data == CHAR_XOFF) begin
        st_next.xoff = 1'b1;
      end else if (st_reg.flow == FLOW_XON &&
                   rx_char.data == CHAR_XON) begin
        st_next.xoff = 1'b0;
      end else if (!rxq_push) begin
        st_next.ovr_flag = 1'b1;
      end
    end
    if (st_reg.flow != FLOW_XON) begin
      st_next.xoff = 1'b0;
    end

    // Receive queue pointers
    if (rxq_push) st_next.wr_ptr = st_reg.wr_ptr + 7'h01;
    if (rxq_pop)  st_next.rd_ptr = st_reg.rd_ptr + 7'h01;
    st_next.count = st_reg.count + 8'(rxq_push) - 8'(rxq_pop);

    // Handshake lines; released again once the queue drains below mark
    st_next.dtr = st_reg.serial;
    st_next.rts = st_reg.serial;
    case (st_reg.flow)
      FLOW_DTR:   st_next.dtr = st_reg.serial & ~rx_high;
      FLOW_RTS:   st_next.rts = st_reg.serial & ~rx_high;
      FLOW_MODEM: st_next.rts = st_reg.serial & ~rx_high;
      default:    st_next.dtr = st_reg.serial;
    endcase

    // Transmitter: mark idle, start, data LSB first, parity, stop
    if (buf_pop) begin
      st_next.tx_st    = S_START;
      st_next.tx_sub   = 4'h0;
      st_next.tx_bitn  = 3'h0;
      st_next.tx_shift = ld;
      st_next.tx_par   = (^ld) ^ (st_reg.fmt == FMT_ODD7);
      st_next.txd      = 1'b0;
    end else if (st_reg.tick && st_reg.tx_st != S_IDLE) begin
      st_next.tx_sub = st_reg.tx_sub + 4'h1;
      if (st_reg.tx_sub == 4'hF) begin
        case (st_reg.tx_st)
          S_START: begin
            st_next.tx_st = S_DATA;
            st_next.txd   = st_reg.tx_shift[0];
          end
          S_DATA: begin
            st_next.tx_shift = {1'b0, st_reg.tx_shift[7:1]};
            st_next.tx_bitn  = st_reg.tx_bitn + 3'h1;
            st_next.txd      = st_reg.tx_shift[1];
            if (st_reg.tx_bitn ==
                ((st_reg.fmt == FMT_NONE8) ? 3'h7 : 3'h6)) begin
              if (st_reg.fmt == FMT_NONE8) begin
                st_next.tx_st = S_STOP;
                st_next.txd   = 1'b1;
              end else begin
                st_next.tx_st = S_PAR;
                st_next.txd   = st_reg.tx_par;
              end
            end
          end
          S_PAR: begin
            st_next.tx_st = S_STOP;
            st_next.txd   = 1'b1;
          end
          S_STOP:  st_next.tx_st = S_IDLE;
          default: st_next.tx_st = S_IDLE;
        endcase
      end
    end
    if (st_next.tx_st == S_IDLE) begin
      st_next.txd = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{baud_sel: BAUD_RST, fmt: FMT_RST, flow: FLOW_RST,
                  serial: SERIAL_RST, panel: PANEL_RST,
                  tx_st: S_IDLE, txd: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Queue storage needs no reset; count says what is valid
  always_ff @(posedge pclk) begin
    if (rxq_push) begin
      rxq_mem[st_reg.wr_ptr] <= {rx_char.perr, rx_char.data};
    end
  end

  tx_buf2 u_tx_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (buf_push),
    .in_data   (pwdata[7:0]),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out_data),
    .out_ready (buf_pop),
    .flush     (buf_flush)
  );

  rx_core u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (st_reg.tick),
    .rxd     (rxd),
    .fmt     (st_reg.fmt),
    .rx_out  (rx_char)
  );
endmodule : rs232_port

//--- rs232_port_assertions.sv
// Checker on the serial port's bus and line ports.
// Assumes the bind below; one clock domain.
`timescale 1ns/1ps
module rs232_port_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        txd,
  input wire logic        rts,
  input wire logic        dtr,
  input wire logic        serial_active,
  input wire logic        keys_locked,
  input wire logic        local_key_locked,
  input wire logic        abort_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answer shape; an error answer only for unmapped places
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_read_no_wait: assert property (psel && !penable && !pwrite |=> pready)
    else $error("read not answered at once");
  a_err_unmapped: assert property (pready && pslverr |->
    (paddr > 12'h00C || paddr[1:0] != 2'h0) && (pwrite || prdata == 32'h0))
    else $error("bad error answer");
  // Panel, abort and line behaviour
  a_rwl_locks_all: assert property (local_key_locked |-> keys_locked)
    else $error("lockout without remote");
  a_abort_pulse: assert property (abort_pulse |=> !abort_pulse)
    else $error("abort pulse too long");
  a_lines_deselect: assert property (!serial_active [*2] |-> !dtr && !rts)
    else $error("handshake line true while parallel bus selected");
  a_start_needs_sel: assert property ($fell(txd) |-> serial_active)
    else $error("frame started while deselected");
  a_start_bit_held: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit too short");
  c_abort: cover property (abort_pulse);
  c_err: cover property (pready && pslverr);
  c_lockout: cover property (local_key_locked);
endmodule : rs232_port_assertions

bind rs232_port rs232_port_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txd(txd), .rts(rts), .dtr(dtr),
  .serial_active(serial_active), .keys_locked(keys_locked),
  .local_key_locked(local_key_locked), .abort_pulse(abort_pulse)
);

//--- host_term.sv
// Host terminal model: framed sender, receiver and ready lines.
// Assumes BIT clocks per bit; 7-bit formats land with parity as bit 7.
`timescale 1ns/1ps
module host_term #(
  parameter int BIT = 432
) (
  input  wire logic  pclk,
  input  wire logic  txd,
  output logic       rxd,
  output logic       cts,
  output logic       dsr,
  output logic [7:0] got,
  output logic       got_stb
);
  // Line idles at mark, host starts on-line and ready
  initial begin
    rxd = 1'b1;
    cts = 1'b1;
    dsr = 1'b1;
    got = 8'h00;
    got_stb = 1'b0;
  end
  task automatic lines(input logic c, input logic d);
    @(posedge pclk);
    cts <= c;
    dsr <= d;
  endtask : lines
  // One start, eight bits LSB first, one stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge pclk);
    end
  endtask : send
  // Short low pulse; a receiver must drop it at mid-bit
  task automatic glitch;
    @(posedge pclk);
    rxd <= 1'b0;
    repeat (BIT / 4) @(posedge pclk);
    rxd <= 1'b1;
    repeat (BIT) @(posedge pclk);
  endtask : glitch
  // Receiver samples bit centres; a low stop bit gives no strobe
  initial forever begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge pclk);
      got[i] <= txd;
    end
    repeat (BIT) @(posedge pclk);
    got_stb <= txd;
    @(posedge pclk);
    got_stb <= 1'b0;
  end
endmodule : host_term

//--- rs232_port_with_flow_control_tb.sv
// Bench: APB master, host terminal and a watcher comparing notes.
// Assumes 115200 baud during traffic, so a frame is ten BIT periods.
`timescale 1ns/1ps
module rs232_port_with_flow_control_tb;
  import rs232_pkg::*;
  localparam int BIT = 16 * int'(DIV_115200);
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, rxd, txd, cts, dsr, rts, dtr, got_stb;
  logic        serial_active, keys_locked, local_key_locked, abort_pulse;
  logic [7:0]  got;
  int          miscompares = 0;
  int          check_count = 0;
  int          aborts = 0;
  logic [32:0] exp_rd[$];
  logic [7:0]  exp_tx[$];

  always #10 pclk = ~pclk;

  rs232_port u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .cts(cts),
    .dsr(dsr), .rts(rts), .dtr(dtr), .serial_active(serial_active),
    .keys_locked(keys_locked), .local_key_locked(local_key_locked),
    .abort_pulse(abort_pulse)
  );
  host_term #(.BIT(BIT)) u_host (
    .pclk(pclk), .txd(txd), .rxd(rxd), .cts(cts), .dsr(dsr), .got(got),
    .got_stb(got_stb)
  );

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  // One transfer; a stalled write may wait out a whole frame
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20000);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20000) begin
      miscompares++;
      finish_test;
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic drain;
    for (int n = 0; n < 30000 && exp_tx.size() > 0; n++) @(posedge pclk);
    if (exp_tx.size() > 0) begin
      miscompares++;
      finish_test;
    end
  endtask : drain

  // Watcher: a finished read or a host char against the oldest note
  always @(posedge pclk) begin
    if (abort_pulse === 1'b1) aborts++;
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata}, exp_rd.pop_front());
    if (got_stb === 1'b1)
      check(33'(got), exp_tx.size() > 0 ?
            33'(exp_tx.pop_front()) : 33'h100);
  end

  initial begin
    logic [7:0] d;
    void'($urandom(69159));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL, 33'h26);
    rd(12'h010, 33'h100000000);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CTRL, 32'h127 | 32'(p) << 9);
      repeat (2) @(posedge pclk);
      check(33'({serial_active, dtr, rts, keys_locked, local_key_locked}),
            33'({3'h7, p != 0, p == 2}));
    end
    // Formats 0 to 2, parity landing in bit 7 of the host's byte
    for (int f = 0; f < 3; f++) begin
      d = 8'($urandom);
      wr(ADDR_CTRL, 32'h127 | 32'(f) << 3);
      exp_tx.push_back(f == 0 ? d : {f == 1 ? ^d[6:0] : ~^d[6:0], d[6:0]});
      wr(ADDR_TXDATA, 32'(d));
      drain;
    end
    // Suspend fills the buffer so the third write stalls until resume
    wr(ADDR_CTRL, 32'h127);
    u_host.send(CHAR_XOFF);
    repeat (20) @(posedge pclk);
    rd(ADDR_STATUS, 33'h5);
    fork
      for (int i = 0; i < 3; i++) wr(ADDR_TXDATA, 32'h41 + 32'(i));
      begin
        repeat (3 * BIT) @(posedge pclk);
        u_host.send(CHAR_XON);
        for (int i = 0; i < 3; i++) exp_tx.push_back(8'h41 + 8'(i));
      end
    join
    drain;
    // Line gates: dsr, cts, then cts in the modem mode
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CTRL, 32'h107 | 32'(m + 2) << 5);
      u_host.lines(m == 0, m != 0);
      wr(ADDR_TXDATA, 32'h5A);
      repeat (2 * BIT) @(posedge pclk);
      // The 5AH frame opens with two low bits, start and bit 0, so a start that slipped the gate
      // still shows as a low line here
      check(33'({dtr, rts, txd}), 33'h7);
      exp_tx.push_back(8'h5A);
      u_host.lines(1'b1, 1'b1);
      drain;
    end
    u_host.lines(1'b0, 1'b1);
    wr(ADDR_TXDATA, 32'h31);
    wr(ADDR_TXDATA, 32'h32);
    u_host.send(CHAR_ABORT);
    repeat (20) @(posedge pclk);
    rd(ADDR_STATUS, 33'h9);
    check(33'(aborts), 33'h1);
    wr(ADDR_STATUS, 32'h8);
    rd(ADDR_STATUS, 33'h1);
    u_host.lines(1'b1, 1'b1);
    repeat (11 * BIT) @(posedge pclk);
    // Receive: a glitch is dropped, one real char is queued
    wr(ADDR_CTRL, 32'h107);
    d = 8'($urandom) | 8'h80;
    u_host.glitch();
    u_host.send(d);
    repeat (20) @(posedge pclk);
    rd(ADDR_RXDATA, 33'h100 | 33'(d));
    rd(ADDR_RXDATA, 33'h0);
    wr(ADDR_CTRL, 32'h007);
    repeat (2) @(posedge pclk);
    check(33'({serial_active, dtr, rts}), 33'h0);
    check(33'(exp_tx.size()), 33'h0);
    finish_test;
  end
endmodule : rs232_port_with_flow_control_tb
